// ===== core/cms_frame_counter.sv
// Shared frame and multiframe counter with parity and keystream init value
`timescale 1ns/1ps
`default_nettype none
module cms_frame_counter
  import cms_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Frame timing
  input  wire logic          frame_start,
  input  wire logic          sync_load,
  input  wire cms_frame_type sync_frame,
  // Derived timing
  output logic               frame_go,
  output logic               frame_odd,
  output logic [IV_W-1:0]    iv
);

  cms_frame_type frame_reg, frame_next;
  logic          go_reg, go_next;

  // ==========================================================================
  // Next values
  always_comb begin
    frame_next = frame_reg;
    go_next    = frame_start;
    if (sync_load) begin
      frame_next = sync_frame;
    end else if (frame_start) begin
      if (frame_reg.frame_num == FRAME_LAST) begin
        frame_next.frame_num = FRAME_RESET;
        frame_next.mf_num    = frame_reg.mf_num + 24'h000001;
      end else begin
        frame_next.frame_num = frame_reg.frame_num + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_reg <= '{mf_num: MF_RESET, frame_num: FRAME_RESET};
      go_reg    <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      go_reg    <= go_next;
    end
  end

  // Alignment relies only on the shared numbering, no extra exchange
  assign frame_go  = go_reg;
  assign frame_odd = frame_reg.frame_num[FRAME_PARITY_BIT];
  // New init value each frame from frame and multiframe number
  assign iv        = {{IV_PAD_W{1'b0}}, frame_reg.mf_num, frame_reg.frame_num};

endmodule // cms_frame_counter
`default_nettype wire

// ===== core/cms_frame_timer.sv
// Saturating frame offset counter used for the confirm retry deadline
`timescale 1ns/1ps
`default_nettype none
module cms_frame_timer
  import cms_pkg::*;
#(
  parameter int W = RETRY_CNT_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic         tick,
  // Offset from the request frame
  output logic [W-1:0]      count
);

  logic [W-1:0] count_reg, count_next;

  // ==========================================================================
  // Saturate so a stuck procedure cannot wrap back into the retry window
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = '0;
    end else if (tick && count_reg != {W{1'b1}}) begin
      count_next = count_reg + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule // cms_frame_timer
`default_nettype wire

// ===== core/cms_ft_mode_ctrl.sv
// Fixed-end controller for switching a connection between clear and cipher mode
// Overview of operation
// - Mode-control tail messages travel on a duplex bearer of the connection.
// - Fixed end sends mode messages only in odd frames, first half.
// - Mode-control tail messages are never enciphered.
// - A switch covers all bearers; later bearers adopt the current mode.
// - Fixed end enciphers at once, confirms odd frames 2S+1 to 2S+11, else releases.
// - Fixed end receives 2S+1 clear, discards until acknowledge, then decrypts and indicates.
// - Fixed end may refuse, in odd frames, only a stored-key request.
// - Stored-key switches carry the key index in every cipher-on message.
// - Fixed end goes clear at once, confirms odd frames to 2S+11, else releases.
// - Fixed end receives 2S+1 enciphered, discards until acknowledge, stops decrypting.
// - Keystream generator restarts each enciphered frame from frame and multiframe number.
// - Keystream alignment relies only on shared synchronised frame numbering.
`timescale 1ns/1ps
`default_nettype none
module cms_ft_mode_ctrl
  import cms_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Frame timing
  input  wire logic          frame_start,
  input  wire logic          sync_load,
  input  wire cms_frame_type sync_frame,
  // Received mode-control tail message and local policy
  input  wire cms_msg_type   rx_msg,
  input  wire logic          refuse_stored_key,
  // Transmitted mode-control tail message
  output cms_msg_type        tx_msg,
  // Cipher path control
  output logic               tx_cipher,
  output logic               tx_tail_cipher,
  output logic               rx_cipher,
  output logic               rx_discard,
  output logic [IV_W-1:0]    iv,
  output logic [KEY_IDX_W-1:0] active_key_idx,
  output logic               conn_cipher_mode,
  // Primitives towards upper layer
  output logic               cipher_switch_indication_prim,
  output logic               ind_cipher_on,
  output logic               link_release_indication
);

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_ENC,
    ST_ON_CONF,
    ST_ON_REJ,
    ST_OFF_CONF
  } cms_state_type;

  // ==========================================================================
  // Frame counter and retry deadline
  logic                   frame_go;
  logic                   frame_odd;
  logic [RETRY_CNT_W-1:0] ofs;
  logic                   timer_load;

  cms_frame_counter u_frame_counter (
    .clk        (clk),
    .rst        (rst),
    .frame_start(frame_start),
    .sync_load  (sync_load),
    .sync_frame (sync_frame),
    .frame_go   (frame_go),
    .frame_odd  (frame_odd),
    .iv         (iv)
  );

  cms_frame_timer #(
    .W(RETRY_CNT_W)
  ) u_frame_timer (
    .clk  (clk),
    .rst  (rst),
    .load (timer_load),
    .tick (frame_start),
    .count(ofs)
  );

  // ==========================================================================
  // State
  cms_state_type          state_reg, state_next;
  cms_msg_type            tx_reg, tx_next;
  logic                   tx_cipher_reg, tx_cipher_next;
  logic                   rx_cipher_reg, rx_cipher_next;
  logic                   req_key_reg, req_key_next;
  logic [KEY_IDX_W-1:0]   key_idx_reg, key_idx_next;
  logic                   ind_reg, ind_next;
  logic                   ind_on_reg, ind_on_next;
  logic                   rel_reg, rel_next;

  // Messages from the portable end count only in even frames
  logic rx_ok;
  logic on_req_now;
  logic off_req_now;
  logic on_grant_now;
  logic off_grant_now;
  logic pending;
  logic deadline;

  always_comb begin
    rx_ok         = rx_msg.valid && !frame_odd;
    // Only the portable end opens a switch; this end merely answers
    on_req_now    = rx_ok && rx_msg.cmd == CMD_ON_REQ && state_reg == ST_CLEAR;
    off_req_now   = rx_ok && rx_msg.cmd == CMD_OFF_REQ && state_reg == ST_ENC;
    on_grant_now  = rx_ok && rx_msg.cmd == CMD_ON_GRANT && state_reg == ST_ON_CONF;
    off_grant_now = rx_ok && rx_msg.cmd == CMD_OFF_GRANT && state_reg == ST_OFF_CONF;
    pending       = state_reg == ST_ON_CONF || state_reg == ST_OFF_CONF;
    deadline      = ofs >= RELEASE_OFS;
  end

  // ==========================================================================
  // Next values
  always_comb begin
    state_next     = state_reg;
    tx_next        = tx_reg;
    tx_cipher_next = tx_cipher_reg;
    rx_cipher_next = rx_cipher_reg;
    req_key_next   = req_key_reg;
    key_idx_next   = key_idx_reg;
    ind_next       = 1'b0;
    ind_on_next    = ind_on_reg;
    rel_next       = 1'b0;
    timer_load     = 1'b0;

    // Each frame opens with a fresh tail slot; odd frames only
    if (frame_go) begin
      tx_next = MSG_IDLE;
      if (frame_odd && ofs >= CONF_FIRST_OFS && ofs <= CONF_LAST_OFS) begin
        tx_next.has_key = req_key_reg;
        tx_next.key_idx = key_idx_reg;
        if (state_reg == ST_ON_CONF) begin
          tx_next.valid = 1'b1;
          tx_next.cmd   = CMD_ON_CONF;
        end else if (state_reg == ST_ON_REJ) begin
          tx_next.valid = 1'b1;
          tx_next.cmd   = CMD_ON_REJECT;
        end else if (state_reg == ST_OFF_CONF) begin
          tx_next.valid   = 1'b1;
          tx_next.cmd     = CMD_OFF_CONF;
          tx_next.has_key = 1'b0;
        end
      end
    end

    case (state_reg)
      ST_CLEAR: begin
        if (on_req_now) begin
          timer_load   = 1'b1;
          req_key_next = rx_msg.has_key;
          key_idx_next = rx_msg.key_idx;
          // Refusal only for a stored-key request
          if (rx_msg.has_key && refuse_stored_key) begin
            state_next = ST_ON_REJ;
          end else begin
            state_next     = ST_ON_CONF;
            tx_cipher_next = 1'b1;
          end
        end
      end
      ST_ENC: begin
        if (off_req_now) begin
          timer_load     = 1'b1;
          state_next     = ST_OFF_CONF;
          tx_cipher_next = 1'b0;
        end
      end
      ST_ON_REJ: begin
        if (frame_go && ofs > CONF_LAST_OFS) begin
          state_next = ST_CLEAR;
        end
      end
      ST_ON_CONF: begin
        if (on_grant_now) begin
          state_next     = ST_ENC;
          rx_cipher_next = 1'b1;
          ind_next       = 1'b1;
          ind_on_next    = 1'b1;
        end else if (frame_go && deadline) begin
          state_next     = ST_CLEAR;
          tx_cipher_next = 1'b0;
          rx_cipher_next = 1'b0;
          rel_next       = 1'b1;
        end
      end
      ST_OFF_CONF: begin
        if (off_grant_now) begin
          state_next     = ST_CLEAR;
          rx_cipher_next = 1'b0;
          ind_next       = 1'b1;
          ind_on_next    = 1'b0;
        end else if (frame_go && deadline) begin
          // Link goes down; the next connection starts clear
          state_next     = ST_CLEAR;
          rx_cipher_next = 1'b0;
          rel_next       = 1'b1;
        end
      end
      default: begin
        state_next = ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= ST_CLEAR;
      tx_reg        <= MSG_IDLE;
      tx_cipher_reg <= 1'b0;
      rx_cipher_reg <= 1'b0;
      req_key_reg   <= 1'b0;
      key_idx_reg   <= KEY_IDX_RESET;
      ind_reg       <= 1'b0;
      ind_on_reg    <= 1'b0;
      rel_reg       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      tx_reg        <= tx_next;
      tx_cipher_reg <= tx_cipher_next;
      rx_cipher_reg <= rx_cipher_next;
      req_key_reg   <= req_key_next;
      key_idx_reg   <= key_idx_next;
      ind_reg       <= ind_next;
      ind_on_reg    <= ind_on_next;
      rel_reg       <= rel_next;
    end
  end

  // ==========================================================================
  // Outputs
  // Tail slot goes out on the duplex bearer carrying this control path
  assign tx_msg           = tx_reg;
  assign tx_cipher        = tx_cipher_reg;
  // A tail holding a mode message bypasses the cipher
  assign tx_tail_cipher   = tx_cipher_reg && !tx_reg.valid;
  // Frame with the acknowledge is already on the new receive mode
  assign rx_cipher        = on_grant_now ? 1'b1 : (off_grant_now ? 1'b0 : rx_cipher_reg);
  assign rx_discard       = pending && ofs >= DISCARD_FROM_OFS && !on_grant_now && !off_grant_now;
  assign active_key_idx   = key_idx_reg;
  // Every bearer, and any set up later, follows this one mode
  assign conn_cipher_mode = tx_cipher_reg;
  assign cipher_switch_indication_prim = ind_reg;
  assign ind_cipher_on    = ind_on_reg;
  assign link_release_indication = rel_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence on_granted_s;
    on_grant_now && rx_cipher ##1 cipher_switch_indication_prim && ind_cipher_on;
  endsequence

  sequence off_granted_s;
    off_grant_now && !rx_cipher ##1 cipher_switch_indication_prim && !ind_cipher_on;
  endsequence

  tail_never_ciphered_a: assert property (tx_msg.valid |-> !tx_tail_cipher)
    else $error("mode message tail would be enciphered");
  even_slot_quiet_a: assert property (frame_go && !frame_odd |=> !tx_msg.valid)
    else $error("mode message sent in an even frame");
  conf_each_odd_a: assert property (state_reg == ST_ON_CONF && frame_go && frame_odd && ofs <= CONF_LAST_OFS
                                    |=> tx_msg.valid && tx_msg.cmd == CMD_ON_CONF)
    else $error("cipher-on confirm missing in odd frame");
  enc_at_once_a: assert property (on_req_now && !(rx_msg.has_key && refuse_stored_key)
                                  |=> tx_cipher ##1 !rx_discard)
    else $error("encrypt mode not entered on request");
  release_on_timeout_a: assert property (pending && frame_go && deadline && !on_grant_now && !off_grant_now
                                         |=> link_release_indication && !tx_cipher && state_reg == ST_CLEAR)
    else $error("no release after confirm window");
  discard_window_a: assert property (pending && ofs < DISCARD_FROM_OFS |-> !rx_discard)
    else $error("first frame after request was discarded");
  grant_decrypts_a: assert property (on_grant_now |-> on_granted_s)
    else $error("cipher-on acknowledge not decrypted or reported");
  grant_stops_a: assert property (off_grant_now |-> off_granted_s)
    else $error("cipher-off acknowledge not handled");
  reject_keyed_only_a: assert property (tx_msg.valid && tx_msg.cmd == CMD_ON_REJECT |-> req_key_reg && !tx_cipher)
    else $error("refusal sent for a request without key index");
  key_idx_carried_a: assert property (tx_msg.valid && tx_msg.cmd != CMD_OFF_CONF && req_key_reg
                                      |-> tx_msg.has_key && tx_msg.key_idx == key_idx_reg)
    else $error("key index missing from cipher-on message");
  off_clear_at_once_a: assert property (off_req_now |=> !tx_cipher && rx_cipher)
    else $error("clear mode not entered on cipher-off request");
  // Confirms and refusals stop after offset 11, whatever the state
  conf_window_end_a: assert property (frame_go && ofs > CONF_LAST_OFS |=> !tx_msg.valid)
    else $error("mode message sent after the confirm window");
  ind_one_pulse_a: assert property (cipher_switch_indication_prim |=> !cipher_switch_indication_prim)
    else $error("indication held for more than one cycle");

endmodule // cms_ft_mode_ctrl
`default_nettype wire

// ===== core/cms_pkg.sv
// Shared constants and types for the fixed-end cipher mode switch controller
package cms_pkg;

  // ==========================================================================
  // Widths
  localparam int KEY_IDX_W   = 4;
  localparam int FRAME_NUM_W = 4;
  localparam int MF_NUM_W    = 24;
  localparam int IV_W        = 35;
  localparam int RETRY_CNT_W = 4;
  localparam int IV_PAD_W    = IV_W - FRAME_NUM_W - MF_NUM_W;

  // ==========================================================================
  // Frame numbering
  localparam logic [FRAME_NUM_W-1:0] FRAME_LAST     = 4'hF;
  localparam logic [FRAME_NUM_W-1:0] FRAME_RESET    = 4'h0;
  localparam logic [MF_NUM_W-1:0]    MF_RESET       = 24'h000000;
  localparam int                     FRAME_PARITY_BIT = 0;

  // ==========================================================================
  // Frame offsets counted from the request frame 2S
  localparam logic [RETRY_CNT_W-1:0] CONF_FIRST_OFS   = 4'h1;
  localparam logic [RETRY_CNT_W-1:0] CONF_LAST_OFS    = 4'hB;
  localparam logic [RETRY_CNT_W-1:0] DISCARD_FROM_OFS = 4'h2;
  localparam logic [RETRY_CNT_W-1:0] RELEASE_OFS      = 4'hD;
  localparam logic [RETRY_CNT_W-1:0] CNT_RESET        = 4'h0;
  localparam logic [KEY_IDX_W-1:0]   KEY_IDX_RESET    = 4'h0;

  // ==========================================================================
  // Mode-control tail commands
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ON_REQ,
    CMD_ON_CONF,
    CMD_ON_REJECT,
    CMD_ON_GRANT,
    CMD_OFF_REQ,
    CMD_OFF_CONF,
    CMD_OFF_GRANT
  } cms_cmd_type;

  typedef struct packed {
    logic                 valid;
    cms_cmd_type          cmd;
    logic                 has_key;
    logic [KEY_IDX_W-1:0] key_idx;
  } cms_msg_type;

  typedef struct packed {
    logic [MF_NUM_W-1:0]    mf_num;
    logic [FRAME_NUM_W-1:0] frame_num;
  } cms_frame_type;

  localparam cms_msg_type MSG_IDLE = '{valid: 1'b0, cmd: CMD_NONE, has_key: 1'b0, key_idx: KEY_IDX_RESET};

endpackage

// ===== tb/cms_ft_mode_ctrl_bench.sv
// Self-checking bench for the fixed-end cipher mode switch controller
`timescale 1ns/1ps
`default_nettype none
module cms_ft_mode_ctrl_bench
  import cms_pkg::*;
;
  // ==========================================================================
  // Signals
  logic                 clk, rst, frame_start, fs_d, sync_load, refuse_stored_key;
  logic                 sw_req, use_key, no_grant, cfm_pulse, rel_pulse;
  logic [2:0]           fcnt;
  logic [3:0]           fn;
  logic [KEY_IDX_W-1:0] key_sel, active_key_idx;
  logic [IV_W-1:0]      iv;
  logic                 tx_cipher, tx_tail_cipher, rx_cipher, rx_discard, conn_cipher_mode;
  logic                 cipher_switch_indication_prim, ind_cipher_on, link_release_indication;
  cms_frame_type        sync_frame;
  cms_msg_type          rx_msg, tx_msg, pt_msg, inj;
  int                   num_errors, checked, nconf, nind;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Frame strobe every 8 cycles, with a mirror of the frame number
  always @(posedge clk) begin
    fs_d <= frame_start;
    fcnt <= rst ? 3'h0 : fcnt + 3'h1;
    frame_start <= !rst && fcnt == 3'h6;
    if (rst) fn <= 4'h0;
    else if (sync_load) fn <= sync_frame.frame_num;
    else if (frame_start) fn <= fn + 4'h1;
  end

  assign rx_msg = inj.valid ? inj : pt_msg;

  cms_ft_mode_ctrl cms_ft_mode_ctrl_i (.clk(clk), .rst(rst), .frame_start(frame_start),
    .sync_load(sync_load), .sync_frame(sync_frame), .rx_msg(rx_msg),
    .refuse_stored_key(refuse_stored_key), .tx_msg(tx_msg), .tx_cipher(tx_cipher),
    .tx_tail_cipher(tx_tail_cipher), .rx_cipher(rx_cipher), .rx_discard(rx_discard), .iv(iv),
    .active_key_idx(active_key_idx), .conn_cipher_mode(conn_cipher_mode),
    .cipher_switch_indication_prim(cipher_switch_indication_prim), .ind_cipher_on(ind_cipher_on),
    .link_release_indication(link_release_indication));

  cms_pt_model cms_pt_model_i (.clk(clk), .rst(rst), .frame_start(frame_start), .frame_odd(fn[0]),
    .sw_req(sw_req), .use_key(use_key), .key_sel(key_sel), .no_grant(no_grant), .tx_msg(tx_msg),
    .rx_msg(pt_msg), .cfm_pulse(cfm_pulse), .rel_pulse(rel_pulse));

  // ==========================================================================
  // Helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: return frame_start;
      1: return pt_msg.valid;
      default: return link_release_indication;
    endcase
  endfunction

  task automatic wait_on(input int sel, input int lim);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (hit(sel) !== 1'b1 && i < lim);
    if (hit(sel) !== 1'b1) begin
      $display("unexpected at %0t: wait ran out", $time);
      num_errors++;
      end_sim();
    end
  endtask

  // tx_msg lags fn by a cycle, so the cycle after frame_start is skipped
  always @(negedge clk) begin
    if (frame_start === 1'b1 && tx_msg.valid === 1'b1) nconf++;
    if (cipher_switch_indication_prim === 1'b1) nind++;
    if (rst === 1'b0 && fs_d === 1'b0 && tx_msg.valid === 1'b1) begin
      check(fn[0], 1'b1);
      check(tx_tail_cipher, 1'b0);
    end
  end

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    @(negedge clk);
    check(tx_msg, MSG_IDLE);
    check({tx_cipher, rx_cipher, rx_discard, conn_cipher_mode, link_release_indication}, 5'h00);
    check(iv, '0);
    $display("test reset done");
  endtask

  task automatic inject(input cms_msg_type m);
    @(posedge clk) inj <= m;
    @(posedge clk) inj <= MSG_IDLE;
    repeat (2) @(negedge clk);
    check({tx_cipher, rx_cipher, cipher_switch_indication_prim}, 3'h0);
  endtask

  task automatic t_stray;
    do wait_on(0, 20); while (fn[0] !== 1'b0);
    inject('{1'b1, CMD_ON_REQ, 1'b0, 4'h0});
    wait_on(0, 20);
    inject('{1'b1, CMD_ON_GRANT, 1'b0, 4'h0});
    $display("test stray messages done");
  endtask

  task automatic t_switch(input logic on, input logic key, input logic refuse, input logic grant);
    logic       rej;
    logic [3:0] s;
    rej = on && key && refuse;
    @(posedge clk);
    use_key <= key;
    refuse_stored_key <= refuse;
    no_grant <= !grant;
    sw_req <= 1'b1;
    @(posedge clk) sw_req <= 1'b0;
    wait_on(1, 40);
    s = fn;
    @(negedge clk);
    check(tx_cipher, on && !rej);
    wait_on(0, 20);
    repeat (2) @(negedge clk);
    check({rx_discard, rx_cipher}, {1'b0, !on});
    check(tx_msg.cmd, rej ? CMD_ON_REJECT : on ? CMD_ON_CONF : CMD_OFF_CONF);
    if (on) check({tx_msg.has_key, tx_msg.key_idx, active_key_idx}, {key, 4'hA, 4'hA});
    nconf = 0;
    nind = 0;
    if (rej) begin
      repeat (120) @(negedge clk);
      check(nconf, 6);
      check({nind != 0, conn_cipher_mode, tx_cipher}, 3'h0);
    end else if (!grant) begin
      wait_on(2, 200);
      check(4'(fn - s), 4'hD);
      check(nconf, 6);
      check({tx_cipher, rx_cipher}, 2'b00);
    end else begin
      wait_on(0, 20);
      repeat (2) @(negedge clk);
      check(rx_discard, 1'b1);
      wait_on(1, 20);
      check({rx_cipher, rx_discard}, {on, 1'b0});
      @(negedge clk);
      check({cipher_switch_indication_prim, ind_cipher_on, conn_cipher_mode}, {1'b1, on, on});
      repeat (24) @(negedge clk);
      check(nconf, 1);
    end
    $display("test switch on=%0d key=%0d refuse=%0d grant=%0d done", on, key, refuse, grant);
  endtask

  task automatic t_iv;
    wait_on(0, 20);
    @(posedge clk);
    sync_frame <= '{24'h00ABCD, 4'hF};
    sync_load <= 1'b1;
    @(posedge clk) sync_load <= 1'b0;
    wait_on(0, 20);
    repeat (2) @(negedge clk);
    check(iv, {7'h00, 24'h00ABCE, 4'h0});
    $display("test frame numbering done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    sync_load = 1'b0;
    sync_frame = '0;
    refuse_stored_key = 1'b0;
    sw_req = 1'b0;
    use_key = 1'b0;
    key_sel = 4'hA;
    no_grant = 1'b0;
    inj = MSG_IDLE;
    num_errors = 0;
    checked = 0;
    nconf = 0;
    nind = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_stray();
    t_switch(1'b1, 1'b1, 1'b0, 1'b1);
    t_switch(1'b0, 1'b0, 1'b0, 1'b1);
    t_switch(1'b1, 1'b1, 1'b1, 1'b0);
    t_switch(1'b1, 1'b0, 1'b1, 1'b0);
    // Cipher-off with no acknowledge goes last: the partner stays in cipher mode after it
    t_switch(1'b1, 1'b0, 1'b0, 1'b1);
    t_switch(1'b0, 1'b0, 1'b0, 1'b0);
    t_iv();
    end_sim();
  end
endmodule // cms_ft_mode_ctrl_bench
`default_nettype wire

// ===== tb/cms_pt_model.sv
// Behavioural portable-end partner driving mode-control requests and grants
`timescale 1ns/1ps
`default_nettype none
module cms_pt_model
  import cms_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Shared frame timing
  input  wire logic                 frame_start,
  input  wire logic                 frame_odd,
  // Bench controls
  input  wire logic                 sw_req,
  input  wire logic                 use_key,
  input  wire logic [KEY_IDX_W-1:0] key_sel,
  input  wire logic                 no_grant,
  // Tail messages
  input  wire cms_msg_type          tx_msg,
  output cms_msg_type               rx_msg,
  // Upper layer view
  output logic                      cfm_pulse,
  output logic                      rel_pulse
);
  // ==========================================================================
  // Procedure state
  logic [2:0] phase;
  logic [2:0] tries;
  logic       busy;
  logic       grant_due;
  logic       pt_cipher;

  // Sends in phase 4, clear of frame_start, so the far end never sees both at once
  always_ff @(posedge clk) begin
    rx_msg <= MSG_IDLE;
    cfm_pulse <= 1'b0;
    rel_pulse <= 1'b0;
    phase <= frame_start ? 3'h0 : phase + 3'h1;
    if (rst) begin
      busy <= 1'b0;
      grant_due <= 1'b0;
      pt_cipher <= 1'b0;
      tries <= 3'h0;
    end else begin
      if (sw_req && !busy) begin
        busy <= 1'b1;
        tries <= 3'h0;
      end
      if (!frame_odd && phase == 3'h3) begin
        if (grant_due) begin
          rx_msg <= '{1'b1, pt_cipher ? CMD_OFF_GRANT : CMD_ON_GRANT, use_key, key_sel};
          pt_cipher <= !pt_cipher;
          grant_due <= 1'b0;
        end else if (busy && tries < 3'h5) begin
          rx_msg <= '{1'b1, pt_cipher ? CMD_OFF_REQ : CMD_ON_REQ, use_key, key_sel};
          tries <= tries + 3'h1;
        end else if (busy) begin
          busy <= 1'b0;
          rel_pulse <= 1'b1;
        end
      end
      if (frame_odd && busy && phase == 3'h2 && tx_msg.valid) begin
        if (tx_msg.cmd == (pt_cipher ? CMD_OFF_CONF : CMD_ON_CONF)) begin
          busy <= 1'b0;
          cfm_pulse <= 1'b1;
          grant_due <= !no_grant;
        end else if (tx_msg.cmd == CMD_ON_REJECT && use_key && !pt_cipher) begin
          busy <= 1'b0;
          cfm_pulse <= 1'b1;
        end
      end
    end
  end
endmodule // cms_pt_model
`default_nettype wire
